// ---- rtl/hscp_regs.vh ----
`ifndef HSCP_REGS_VH
`define HSCP_REGS_VH
`define HSCP_CMD_ESC      8'h13
`define HSCP_CMD_RATE     8'h15
`define HSCP_CMD_OUT2     8'h28
`define HSCP_CMD_RADIO    8'h39
`define HSCP_CMD_BASE     8'h3A
`define HSCP_CMD_EXIT     8'h09
`define HSCP_RST_ESC      8'h2B
`define HSCP_RST_RATE     32'h00000003
`define HSCP_RST_OUT2     8'h02
`define HSCP_RST_RADIO    8'h01
`define HSCP_RST_BASE     8'h01
`define HSCP_ESC_MIN      8'h20
`define HSCP_ESC_MAX      8'h7F
`define HSCP_STD_MAX      32'h00000008
`define HSCP_INV_MAX      32'h00000038
`define HSCP_LIT_MAX      32'h001C9C38
`define HSCP_LIT_MIN      32'h00000039
`define HSCP_RST_BPS      32'h00002580
`define HSCP_RST_DIV      32'h00000000
`define HSCP_LEN_RATE     3'h4
`define HSCP_LEN_BYTE     3'h1
`define HSCP_CLK_HZ       32'd125000000
`endif

// ---- rtl/hscp_rate_table.v ----
`timescale 1ns/10ps
`default_nettype none
// Standard rate lookup; result registered
module hscp_rate_table (
	input  wire        mclk,   // Clock
	input  wire [3:0]  code,   // Standard rate code
	output reg  [31:0] bps     // Rate in bits per second
);
	always @(posedge mclk) begin
		case (code)
		4'h0: bps <= 32'h000004B0;
		4'h1: bps <= 32'h00000960;
		4'h2: bps <= 32'h000012C0;
		4'h3: bps <= 32'h00002580;
		4'h4: bps <= 32'h00004B00;
		4'h5: bps <= 32'h00009600;
		4'h6: bps <= 32'h0000E100;
		4'h7: bps <= 32'h0001C200;
		4'h8: bps <= 32'h00038400;
		default: bps <= 32'h00000000;
		endcase
	end
endmodule
`default_nettype wire

// ---- rtl/hscp_param_store.v ----
`timescale 1ns/10ps
`default_nettype none
`include "hscp_regs.vh"

// Summary of operation
// - Rate codes 0..8 select 1200 to 230400 bps in order.
// - New interface rate applies only after exit command and its OK.
// - Rate values 0x09..0x38 are invalid and select nothing.
// - Values 0x39..0x1C9C38 are literal bauds, stored as achievable rate.
// - Reading the rate returns the stored, possibly rounded, value.
// - Interface rate resets to 3 and reads back four bytes.
// - Radio rate is independent of interface rate.
// - Radio rate accepts 0 or 1, resets to 1, reads one byte.
// - Escape char accepts 0x20..0x7F, resets to 0x2B, one byte.
// - Silence, escape char, silence enters command mode.
// - Output two: 0 receive, 1 high, 2 low, 3 reserved, reset 2.
// - Number base accepts 0, 1 or 2, resets to 1.
// - Hex format is forced only when the base is 1, versions and key included.
// - Exit command 0x09 leaves command mode.
module hscp_param_store #(
	parameter CLK_HZ = `HSCP_CLK_HZ
) (
	input  wire        mclk,        // Clock
	input  wire        srst,        // Sync reset
	input  wire        req,         // Command strobe
	input  wire        req_write,   // 1 write, 0 read
	input  wire [7:0]  req_cmd,     // Command code
	input  wire [31:0] req_data,    // Write value
	input  wire        silence_before_escape, // Guard before seen
	input  wire        silence_after_escape,  // Guard after seen
	input  wire        host_byte_valid, // Host byte strobe
	input  wire [7:0]  host_byte,   // Host byte
	input  wire        ok_sent,     // OK of exit command was sent
	input  wire        rx_activity, // Receive indicator source
	output reg         rsp_valid,   // Response strobe
	output reg         rsp_error,   // Response is error
	output reg  [31:0] rsp_data,    // Read value
	output reg  [2:0]  rsp_len,     // Bytes returned
	output reg         cmd_mode_q,  // Command mode active
	output reg  [31:0] active_bps_q, // Rate applied to serial port
	output reg  [31:0] clk_div_q,   // Serial divisor
	output reg         radio_fast_q, // Radio at 115200
	output reg  [7:0]  number_base_q, // Formatting base
	output wire        hex_only,    // Force hex format
	output reg         general_output_two // Output two pin
);
	reg  [7:0]  escape_char_q;
	reg  [31:0] rate_q;
	reg  [7:0]  out2_q;
	reg         pend_q;
	reg         esc_seen_q;
	reg         exit_wait_q;
	reg  [31:0] div_d;
	reg  [31:0] stored_d;
	reg         ok_d;
	reg  [31:0] lit_div_q;
	reg  [31:0] den_d;
	wire [31:0] std_bps;
	wire        wr = req & req_write;
	wire        lit = req_data > `HSCP_INV_MAX;
	wire        rate_wr = wr & ok_d & (req_cmd == `HSCP_CMD_RATE);
	wire        exit_req = req & (req_cmd == `HSCP_CMD_EXIT);
	wire        std_code = rate_q <= `HSCP_STD_MAX;
	wire        apply_now = exit_wait_q & ok_sent & ~(exit_req & cmd_mode_q);

	// ------------------------------------------------------------
	// Standard rate lookup
	// ------------------------------------------------------------
	// Table output trails rate_q by one cycle
	hscp_rate_table u_tab (
		.mclk (mclk),
		.code (rate_q[3:0]),
		.bps  (std_bps)
	);

	// ------------------------------------------------------------
	// Literal rate rounding
	// ------------------------------------------------------------
	always @* begin
		den_d    = (req_data == 32'h0) ? 32'h1 : req_data;
		// Divisor rounds up so the port never runs above the request
		div_d    = (CLK_HZ + den_d - 32'h1) / den_d;
		if (div_d == 32'h0)
			div_d = 32'h1;
		stored_d = CLK_HZ / div_d;
		// The slowest literals would otherwise truncate into the gap
		if (stored_d <= `HSCP_INV_MAX)
			stored_d = `HSCP_LIT_MIN;
		case (req_cmd)
		`HSCP_CMD_RATE:  ok_d = (req_data <= `HSCP_STD_MAX) |
			(lit & (req_data <= `HSCP_LIT_MAX));
		`HSCP_CMD_RADIO: ok_d = req_data <= 32'h1;
		`HSCP_CMD_ESC:   ok_d = (req_data >= {24'h0, `HSCP_ESC_MIN}) &
			(req_data <= {24'h0, `HSCP_ESC_MAX});
		`HSCP_CMD_OUT2:  ok_d = req_data <= 32'h2;
		`HSCP_CMD_BASE:  ok_d = req_data <= 32'h2;
		`HSCP_CMD_EXIT:  ok_d = 1'b1;
		default:         ok_d = 1'b0;
		endcase
	end
	// Hex format is forced only while the base setting is 1; the formatter sees this
	assign hex_only = number_base_q == 8'h01;

	// ------------------------------------------------------------
	// Parameter store and responses
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (srst) begin
			escape_char_q <= `HSCP_RST_ESC;
			rate_q        <= `HSCP_RST_RATE;
			out2_q        <= `HSCP_RST_OUT2;
			radio_fast_q  <= 1'b1;
			number_base_q <= `HSCP_RST_BASE;
			lit_div_q     <= `HSCP_RST_DIV;
			rsp_valid     <= 1'b0;
			rsp_error     <= 1'b0;
			rsp_data      <= 32'h0;
			rsp_len       <= 3'h0;
		end else begin
			rsp_valid <= req;
			if (req) begin
				rsp_error <= ~ok_d;
				rsp_data  <= 32'h0;
				rsp_len   <= `HSCP_LEN_BYTE;
				case (req_cmd)
				`HSCP_CMD_RATE: begin
					rsp_data <= rate_q;
					rsp_len  <= `HSCP_LEN_RATE;
				end
				`HSCP_CMD_RADIO: rsp_data <= {31'h0, radio_fast_q};
				`HSCP_CMD_ESC:   rsp_data <= {24'h0, escape_char_q};
				`HSCP_CMD_OUT2:  rsp_data <= {24'h0, out2_q};
				`HSCP_CMD_BASE:  rsp_data <= {24'h0, number_base_q};
				default:         rsp_data <= 32'h0;
				endcase
			end
			if (wr & ok_d) begin
				case (req_cmd)
				`HSCP_CMD_RATE: begin
					rate_q    <= lit ? stored_d : req_data;
					lit_div_q <= div_d;
				end
				`HSCP_CMD_RADIO: radio_fast_q <= req_data[0];
				`HSCP_CMD_ESC:   escape_char_q <= req_data[7:0];
				`HSCP_CMD_OUT2:  out2_q <= req_data[7:0];
				`HSCP_CMD_BASE:  number_base_q <= req_data[7:0];
				default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Rate apply after exit
	// ------------------------------------------------------------
	// The new rate waits for the OK of the exit, so that reply still
	// leaves at the rate the host is listening on
	always @(posedge mclk) begin
		if (srst) begin
			pend_q       <= 1'b1;
			exit_wait_q  <= 1'b0;
			active_bps_q <= `HSCP_RST_BPS;
			clk_div_q    <= `HSCP_RST_DIV;
		end else begin
			if (exit_req & cmd_mode_q)
				exit_wait_q <= 1'b1;
			else if (exit_wait_q & ok_sent)
				exit_wait_q <= 1'b0;
			// A rate written in the apply cycle stays pending
			if (rate_wr)
				pend_q <= 1'b1;
			else if (apply_now)
				pend_q <= 1'b0;
			if (apply_now & pend_q) begin
				if (std_code) begin
					active_bps_q <= std_bps;
					clk_div_q    <= CLK_HZ / std_bps;
				end else begin
					active_bps_q <= rate_q;
					clk_div_q    <= lit_div_q;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Command mode entry and exit
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (srst) begin
			cmd_mode_q <= 1'b0;
			esc_seen_q <= 1'b0;
		end else if (exit_req) begin
			cmd_mode_q <= 1'b0;
			esc_seen_q <= 1'b0;
		end else if (~cmd_mode_q) begin
			if (host_byte_valid)
				esc_seen_q <= silence_before_escape &
					(host_byte == escape_char_q);
			else if (esc_seen_q & silence_after_escape) begin
				cmd_mode_q <= 1'b1;
				esc_seen_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output two behaviour
	// ------------------------------------------------------------
	// Code 3 is refused at write, so it never reaches this decode
	always @(posedge mclk) begin
		if (srst)
			general_output_two <= 1'b0;
		else
			case (out2_q)
			8'h00: general_output_two <= rx_activity;
			8'h01: general_output_two <= 1'b1;
			default: general_output_two <= 1'b0;
			endcase
	end
endmodule
`default_nettype wire

// ---- test/hscp_param_store_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module hscp_param_store_assertions (
	input wire        mclk,          // Clock
	input wire        srst,          // Sync reset
	input wire        req,           // Command strobe
	input wire        req_write,     // Write select
	input wire [7:0]  req_cmd,       // Command code
	input wire [31:0] req_data,      // Write value
	input wire        ok_sent,       // Exit OK sent
	input wire        rsp_valid,     // Response strobe
	input wire        rsp_error,     // Error answer
	input wire [2:0]  rsp_len,       // Bytes returned
	input wire        cmd_mode_q,    // Command mode
	input wire [31:0] active_bps_q,  // Applied rate
	input wire [7:0]  number_base_q, // Base setting
	input wire        hex_only       // Hex format
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire wr_q = req && req_write;
	a_rsp_next: assert property (req |=> rsp_valid)
		else $error("no answer");
	a_rate_len: assert property (req && !req_write && req_cmd == 8'h15
		|=> rsp_len == 3'h4) else $error("rate length");
	a_radio_len: assert property (req && !req_write && req_cmd == 8'h39
		|=> rsp_len == 3'h1) else $error("radio length");
	a_rate_gap: assert property (wr_q && req_cmd == 8'h15 &&
		req_data > 32'h8 && req_data < 32'h39 |=> rsp_error) else $error("gap");
	a_esc_range: assert property (wr_q && req_cmd == 8'h13 &&
		(req_data < 32'h20 || req_data > 32'h7F) |=> rsp_error) else $error("esc");
	a_out2_resv: assert property (wr_q && req_cmd == 8'h28 &&
		req_data == 32'h3 |=> rsp_error) else $error("reserved");
	a_rate_hold: assert property (!ok_sent |=> $stable(active_bps_q))
		else $error("rate moved early");
	a_exit_idle: assert property (wr_q && req_cmd == 8'h09 |=> !cmd_mode_q)
		else $error("no exit");
	a_hex_base: assert property (hex_only == (number_base_q == 8'h01))
		else $error("base");
endmodule
`default_nettype wire

// ---- test/hscp_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host side: sends OK once the exit command has been answered
module hscp_host_model (
	input  wire       mclk,      // Clock
	input  wire       srst,      // Sync reset
	input  wire       req,       // Command strobe
	input  wire [7:0] req_cmd,   // Command code
	input  wire       rsp_valid, // Response strobe
	output logic      ok_sent    // OK has gone out
);
	logic ex_q;
	always @(posedge mclk) begin
		ok_sent <= !srst && ex_q && rsp_valid;
		if (srst || (ex_q && rsp_valid))
			ex_q <= 1'b0;
		else if (req)
			ex_q <= req_cmd == 8'h09;
	end
endmodule
`default_nettype wire

// ---- test/hscp_param_store_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module hscp_param_store_bench;
	logic mclk = 0, srst = 1, req = 0, req_write = 0, rx_activity = 0;
	logic silence_before_escape = 0, silence_after_escape = 0;
	logic host_byte_valid = 0;
	logic [7:0] req_cmd = 8'h00, host_byte = 8'h00;
	logic [31:0] req_data = 32'h0;
	wire ok_sent, rsp_valid, rsp_error, cmd_mode_q, radio_fast_q, hex_only;
	wire general_output_two;
	wire [31:0] rsp_data, active_bps_q, clk_div_q;
	wire [7:0] number_base_q;
	wire [2:0] rsp_len;
	int fails = 0, total_checks = 0;
	logic [31:0] rt[9] = '{32'h4B0, 32'h960, 32'h12C0, 32'h2580, 32'h4B00,
		32'h9600, 32'hE100, 32'h1C200, 32'h38400};
	hscp_param_store u_hscp_param_store (.*);
	hscp_host_model u_hscp_host_model (.*);
	initial forever #4 mclk = ~mclk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task stop_test;
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmd(input logic w, input logic [7:0] c, input logic [31:0] d);
		@(posedge mclk) {req, req_write, req_cmd, req_data} <= {1'b1, w, c, d};
		@(posedge mclk) req <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] c, input logic [31:0] e, input logic [2:0] l);
		cmd(1'b0, c, 32'h0);
		chk(rsp_data, e);
		chk({29'h0, rsp_len}, {29'h0, l});
	endtask
	task wr(input logic [7:0] c, input logic [31:0] d, input logic e);
		cmd(1'b1, c, d);
		chk({31'h0, rsp_error}, {31'h0, e});
	endtask
	task enter(input logic [7:0] b);
		@(posedge mclk) {silence_before_escape, host_byte_valid} <= 2'h3;
		host_byte <= b;
		@(posedge mclk) {silence_before_escape, host_byte_valid} <= 2'h0;
		silence_after_escape <= 1'b1;
		@(posedge mclk) silence_after_escape <= 1'b0;
		@(posedge mclk) #1;
	endtask
	task t_reset;
		rd(8'h15, 32'h3, 3'h4);
		rd(8'h39, 32'h1, 3'h1);
		rd(8'h13, 32'h2B, 3'h1);
		rd(8'h28, 32'h2, 3'h1);
		rd(8'h3A, 32'h1, 3'h1);
	endtask
	task t_rate;
		wr(8'h15, 32'h9, 1'b1);
		wr(8'h15, 32'h38, 1'b1);
		wr(8'h15, 32'h1C9C39, 1'b1);
		rd(8'h15, 32'h3, 3'h4);
		wr(8'h15, 32'h12C, 1'b0);
		rd(8'h15, 32'h12B, 3'h4);
		for (int i = 0; i < 9; i++) begin
			enter(8'h2B);
			chk({31'h0, cmd_mode_q}, 32'h1);
			wr(8'h15, i, 1'b0);
			cmd(1'b1, 8'h09, 32'h0);
			chk(active_bps_q, i ? rt[i - 1] : 32'h2580);
			repeat (3) @(posedge mclk);
			#1 chk(active_bps_q, rt[i]);
			chk(clk_div_q, 32'd125000000 / rt[i]);
			chk({31'h0, radio_fast_q}, 32'h1);
		end
		enter(8'h2B);
		wr(8'h15, 32'h12C, 1'b0);
		cmd(1'b1, 8'h09, 32'h0);
		repeat (3) @(posedge mclk);
		#1 chk(active_bps_q, 32'h12B);
		chk(clk_div_q, 32'd416667);
	endtask
	task t_fields;
		wr(8'h13, 32'h1F, 1'b1);
		wr(8'h13, 32'h80, 1'b1);
		wr(8'h13, 32'h7F, 1'b0);
		enter(8'h2B);
		chk({31'h0, cmd_mode_q}, 32'h0);
		enter(8'h7F);
		chk({31'h0, cmd_mode_q}, 32'h1);
		wr(8'h28, 32'h3, 1'b1);
		for (int i = 2; i >= 0; i--) begin
			wr(8'h28, i, 1'b0);
			@(posedge mclk) rx_activity <= i == 0;
			repeat (2) @(posedge mclk);
			#1 chk({31'h0, general_output_two}, i != 2);
		end
		@(posedge mclk) rx_activity <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk({31'h0, general_output_two}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h3A, i, i == 3);
			chk({31'h0, hex_only}, i == 1);
		end
		wr(8'h39, 32'h0, 1'b0);
		wr(8'h39, 32'h2, 1'b1);
		chk({31'h0, radio_fast_q}, 32'h0);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		t_reset;
		t_rate;
		t_fields;
		stop_test;
	end
	initial begin
		#100000 fails++;
		stop_test;
	end
endmodule
bind hscp_param_store hscp_param_store_assertions u_chk (
	.mclk          (mclk),
	.srst          (srst),
	.req           (req),
	.req_write     (req_write),
	.req_cmd       (req_cmd),
	.req_data      (req_data),
	.ok_sent       (ok_sent),
	.rsp_valid     (rsp_valid),
	.rsp_error     (rsp_error),
	.rsp_len       (rsp_len),
	.cmd_mode_q    (cmd_mode_q),
	.active_bps_q  (active_bps_q),
	.number_base_q (number_base_q),
	.hex_only      (hex_only)
);
`default_nettype wire
